// *** include/daq_regs_map.vh ***
// register offsets, field positions and bus encoding constants for the daq register file
`ifndef DAQ_REGS_MAP_VH
`define DAQ_REGS_MAP_VH
`define OFS_SCAN_PTR      20'h00008
`define OFS_SCAN_ENTRY    20'h0000C
`define OFS_RESULT_FIFO   20'h0002C
`define OFS_TIMER_DATA    20'h00030
`define OFS_TIMER_CMD     20'h00034
`define OFS_DIGITAL_IN    20'h00038
`define OFS_AOUT0         20'h00020
`define OFS_AOUT1         20'h00024
`define OFS_CONTROL       20'h00000
`define OFS_STATUS        20'h00004
`define OFS_IRQ_CLEAR     20'h40000
`define ADDR_BITS         20
`define CTL_TIMER_UPD     0
`define CTL_TRIG_UPD      1
`define CTL_TWOS          2
`define CTL_DIFFERENTIAL_INPUT_MODE          3
`define CTL_HIGH_GAIN     4
`define CTL_WIDTH         5
`define STS_AVAIL         0
`define STS_IRQ           1
`define STS_FULL          2
`define CMD_PREFIX        8'hFF
`define TIMER_REG_COUNT   18
`define HTRANS_NONSEQ     2'h2
`define HSIZE_WORD        3'h2
`endif

// *** logic/result_fifo.v ***
// conversion result fifo with occupancy flags
module result_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clock,
   input  wire             srst,
   input  wire             pushValid,
   input  wire [WIDTH-1:0] pushData,
   output wire             pushReady,
   input  wire             popReq,
   output wire [WIDTH-1:0] popData,
   output wire             notEmpty,
   output wire             isFull
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];  // storage array
   reg [AW-1:0]    wrPtr_r;          // next write slot
   reg [AW-1:0]    rdPtr_r;          // oldest entry
   reg [AW:0]      count_r;          // occupancy
   wire            doPush;
   wire            doPop;
   assign notEmpty  = (count_r != {(AW+1){1'b0}});
   assign isFull    = (count_r == DEPTH[AW:0]);
   assign pushReady = ~isFull;
   assign doPop     = popReq & notEmpty;
   assign doPush    = pushValid & (~isFull | doPop);
   assign popData   = mem[rdPtr_r];
   // pointer and count update; push and pop may share a cycle
   always @(posedge clock) begin
      if (srst) begin
         wrPtr_r <= {AW{1'b0}};
         rdPtr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
      end else begin
         if (doPush) begin
            mem[wrPtr_r] <= pushData;
            wrPtr_r      <= wrPtr_r + 1'b1;
         end
         if (doPop)
            rdPtr_r <= rdPtr_r + 1'b1;
         if (doPush & ~doPop)
            count_r <= count_r + 1'b1;
         else if (doPop & ~doPush)
            count_r <= count_r - 1'b1;
      end
   end
endmodule

// *** logic/daq_board_register_file.v ***
// ahb-lite register front end of the data-acquisition board
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`include "daq_regs_map.vh"
module daq_board_register_file #(
   parameter FIFO_DEPTH = 16,
   parameter FIFO_AW    = 4
) (
   input  wire        clock,
   input  wire        srst,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp,
   input  wire        convDone,
   input  wire [15:0] convResult,
   output wire        convReady,
   input  wire        timer2Output,
   input  wire        trigBusPulse,
   output reg  [11:0] aoutCh0,
   output reg  [11:0] aoutCh1,
   output reg         timerIrq,
   output reg  [3:0]  scanCount,
   output reg  [3:0]  chanPos,
   output reg  [3:0]  chanNeg,
   output reg         chanNegUsed,
   output reg  [9:0]  ampGain,
   output reg         scanEnd,
   output reg  [7:0]  timerCmd,
   output reg         timerCmdStb,
   output reg  [15:0] timerWrData,
   output reg         timerWrStb,
   output reg         timerRdStb,
   input  wire [15:0] timerRdData,
   input  wire [4:0]  timerOutLevels,
   input  wire        bytePointerState,
   input  wire [3:0]  portAInputBits,
   input  wire [3:0]  portBInputBits
);
   // gain lookup shared by entry write and counter load paths
   function [9:0] gainOf;
      input [1:0] code;
      input       highGain;
      begin
         case (code)
            2'h0:    gainOf = 10'h001;
            2'h1:    gainOf = highGain ? 10'h002 : 10'h00A;
            2'h2:    gainOf = highGain ? 10'h004 : 10'h064;
            default: gainOf = highGain ? 10'h008 : 10'h1F4;
         endcase
      end
   endfunction

   reg  [`CTL_WIDTH-1:0] control_r;   // update, format, mode, variant
   reg  [7:0]  scanMem [0:15];        // scan memory entries
   reg  [11:0] pend0_r;               // loaded, not yet applied
   reg  [11:0] pend1_r;
   reg         dphase_r;              // data phase pending
   reg         dWrite_r;              // pending phase is a write
   reg  [19:0] dAddr_r;               // latched byte address
   reg  [1:0]  t2Sync_r;              // pin synchroniser
   reg  [1:0]  tbSync_r;
   reg  [3:0]  pa0_r, pa1_r, pb0_r, pb1_r;
   reg  [4:0]  to0_r, to1_r;
   reg         bp0_r, bp1_r;
   reg         t2Prev_r;              // edge detect history
   reg         tbPrev_r;
   wire        t2Rise;
   wire        t2Fall;
   wire        tbFall;
   wire        updPulse;
   wire        addrOk;
   wire        wrStb;
   wire        rdFifo;
   wire        fifoNotEmpty;
   wire        fifoFull;
   wire [15:0] fifoData;
   wire [15:0] fmtResult;
   wire [7:0]  entry;
   wire [7:0]  memEntry;

   assign hreadyout = 1'b1;           // zero wait states
   assign hresp     = 1'b0;           // always okay
   assign addrOk = hsel & hready & (htrans == `HTRANS_NONSEQ);
   assign wrStb  = dphase_r & dWrite_r;
   assign rdFifo = addrOk & ~hwrite & (haddr[19:0] == `OFS_RESULT_FIFO);
   assign entry  = hwdata[7:0];
   assign memEntry = scanMem[scanCount];
   // timer outputs are active low update strobes; irq fires on rise
   assign t2Rise = t2Sync_r[1] & ~t2Prev_r;
   assign t2Fall = ~t2Sync_r[1] & t2Prev_r;
   assign tbFall = ~tbSync_r[1] & tbPrev_r;
   assign updPulse = (control_r[`CTL_TIMER_UPD] & t2Fall) |
                     (control_r[`CTL_TRIG_UPD] & tbFall);
   // sign format applied on the way out
   assign fmtResult = control_r[`CTL_TWOS] ?
                      {~fifoData[15], fifoData[14:0]} : fifoData;

   result_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) uFifo (
      .clock     (clock),
      .srst      (srst),
      .pushValid (convDone),
      .pushData  (convResult),
      .pushReady (convReady),
      .popReq    (rdFifo),
      .popData   (fifoData),
      .notEmpty  (fifoNotEmpty),
      .isFull    (fifoFull)
   );

   // two-flop synchronisers for all pin inputs
   always @(posedge clock) begin
      if (srst) begin
         t2Sync_r <= 2'h3;
         tbSync_r <= 2'h3;
         t2Prev_r <= 1'b1;
         tbPrev_r <= 1'b1;
         pa0_r <= 4'h0;
         pa1_r <= 4'h0;
         pb0_r <= 4'h0;
         pb1_r <= 4'h0;
         to0_r <= 5'h00;
         to1_r <= 5'h00;
         bp0_r <= 1'b0;
         bp1_r <= 1'b0;
      end else begin
         t2Sync_r <= {t2Sync_r[0], timer2Output};
         tbSync_r <= {tbSync_r[0], trigBusPulse};
         t2Prev_r <= t2Sync_r[1];
         tbPrev_r <= tbSync_r[1];
         pa0_r <= portAInputBits;
         pa1_r <= pa0_r;
         pb0_r <= portBInputBits;
         pb1_r <= pb0_r;
         to0_r <= timerOutLevels;
         to1_r <= to0_r;
         bp0_r <= bytePointerState;
         bp1_r <= bp0_r;
      end
   end

   // address phase capture; data phase follows next cycle
   always @(posedge clock) begin
      if (srst) begin
         dphase_r <= 1'b0;
         dWrite_r <= 1'b0;
         dAddr_r  <= 20'h00000;
      end else begin
         dphase_r <= addrOk;
         dWrite_r <= addrOk & hwrite;
         if (addrOk)
            dAddr_r <= haddr[19:0];
      end
   end

   // read data registered at the address phase, stands in the data phase
   always @(posedge clock) begin
      if (srst) begin
         hrdata     <= 32'h00000000;
         timerRdStb <= 1'b0;
      end else begin
         timerRdStb <= 1'b0;
         if (addrOk & ~hwrite) begin
            case (haddr[19:0])
               `OFS_RESULT_FIFO: hrdata <= {16'h0000, fmtResult};
               `OFS_TIMER_DATA: begin
                  hrdata     <= {16'h0000, timerRdData};
                  timerRdStb <= 1'b1;
               end
               `OFS_TIMER_CMD:  hrdata <= {26'h0000000, to1_r, bp1_r};
               `OFS_DIGITAL_IN: hrdata <= {24'h000000, pb1_r, pa1_r};
               `OFS_CONTROL:    hrdata <= {27'h0000000, control_r};
               `OFS_STATUS:
                  hrdata <= {29'h00000000, fifoFull, timerIrq, fifoNotEmpty};
               default:         hrdata <= 32'h00000000; // unmapped reads zero
            endcase
         end
      end
   end

   // write side effects in the data phase
   always @(posedge clock) begin
      if (srst) begin
         control_r   <= {`CTL_WIDTH{1'b0}};
         pend0_r     <= 12'h000;
         pend1_r     <= 12'h000;
         aoutCh0     <= 12'h000;
         aoutCh1     <= 12'h000;
         timerIrq    <= 1'b0;
         scanCount   <= 4'h0;
         chanPos     <= 4'h0;
         chanNeg     <= 4'h8;
         chanNegUsed <= 1'b0;
         ampGain     <= 10'h001;
         scanEnd     <= 1'b0;
         timerCmd    <= 8'h00;
         timerCmdStb <= 1'b0;
         timerWrData <= 16'h0000;
         timerWrStb  <= 1'b0;
      end else begin
         timerCmdStb <= 1'b0;
         timerWrStb  <= 1'b0;
         // irq: a new timer edge wins over a clear in the same cycle
         if (t2Rise)
            timerIrq <= 1'b1;
         else if (wrStb & ((dAddr_r == `OFS_IRQ_CLEAR) |
                  (dAddr_r == `OFS_AOUT0) | (dAddr_r == `OFS_AOUT1)))
            timerIrq <= 1'b0;
         // deferred analog update on the selected pulse
         if (updPulse) begin
            aoutCh0 <= pend0_r;
            aoutCh1 <= pend1_r;
         end
         if (wrStb) begin
            case (dAddr_r)
               `OFS_AOUT0: begin
                  pend0_r <= hwdata[11:0];
                  if (~control_r[`CTL_TIMER_UPD] & ~control_r[`CTL_TRIG_UPD])
                     aoutCh0 <= hwdata[11:0];
               end
               `OFS_AOUT1: begin
                  pend1_r <= hwdata[11:0];
                  if (~control_r[`CTL_TIMER_UPD] & ~control_r[`CTL_TRIG_UPD])
                     aoutCh1 <= hwdata[11:0];
               end
               `OFS_SCAN_PTR: scanCount <= hwdata[3:0];
               `OFS_SCAN_ENTRY: begin
                  scanMem[scanCount] <= entry;
                  chanPos <= control_r[`CTL_DIFFERENTIAL_INPUT_MODE] ?
                             {1'b0, entry[2:0]} : entry[3:0];
                  chanNeg     <= {1'b1, entry[2:0]};
                  chanNegUsed <= control_r[`CTL_DIFFERENTIAL_INPUT_MODE];
                  ampGain <= gainOf(entry[7:6], control_r[`CTL_HIGH_GAIN]);
                  scanEnd <= entry[4];
               end
               `OFS_TIMER_CMD: begin
                  timerCmd    <= hwdata[7:0];
                  timerCmdStb <= 1'b1;
               end
               `OFS_TIMER_DATA: begin
                  timerWrData <= hwdata[15:0];
                  timerWrStb  <= 1'b1;
               end
               `OFS_CONTROL: control_r <= hwdata[`CTL_WIDTH-1:0];
               default: ;
            endcase
         end else if (dphase_r & (dAddr_r == `OFS_SCAN_PTR)) begin
            // nothing: a scan pointer read returns zero and leaves the front end as it was
         end else begin
            // pointer-addressed entry drives the analog front end
            chanPos <= control_r[`CTL_DIFFERENTIAL_INPUT_MODE] ?
                       {1'b0, memEntry[2:0]} : memEntry[3:0];
            chanNeg     <= {1'b1, memEntry[2:0]};
            chanNegUsed <= control_r[`CTL_DIFFERENTIAL_INPUT_MODE];
            ampGain <= gainOf(memEntry[7:6], control_r[`CTL_HIGH_GAIN]);
            scanEnd <= memEntry[4];
         end
      end
   end
endmodule

// *** tb/daq_board_register_file_chk.sv ***
// port-level assertions for the daq register file
`include "daq_regs_map.vh"
module daq_board_register_file_chk (
   input wire logic        clock,
   input wire logic        srst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        timer2Output,
   input wire logic        timerIrq,
   input wire logic [3:0]  scanCount,
   input wire logic [3:0]  chanPos,
   input wire logic        scanEnd,
   input wire logic [7:0]  timerCmd,
   input wire logic        timerCmdStb,
   input wire logic [15:0] timerWrData,
   input wire logic        timerWrStb,
   input wire logic [4:0]  timerOutLevels,
   input wire logic        bytePointerState,
   input wire logic [3:0]  portAInputBits,
   input wire logic [3:0]  portBInputBits
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   logic [2:0] quietCnt_r;  // edges since the sampled pins last moved
   // pins pass a synchroniser, so reads are judged only once they settle
   always @(posedge clock) begin
      if (srst || !$stable({timerOutLevels, bytePointerState,
                            portAInputBits, portBInputBits}))
         quietCnt_r <= 3'h0;
      else if (quietCnt_r != 3'h7)
         quietCnt_r <= quietCnt_r + 3'h1;
   end
   // address phases of single transfers
   sequence wr_at(logic [19:0] ofs);
      hsel && hready && htrans == `HTRANS_NONSEQ && hwrite && haddr[19:0] == ofs;
   endsequence
   sequence rd_at(logic [19:0] ofs);
      hsel && hready && htrans == `HTRANS_NONSEQ && !hwrite && haddr[19:0] == ofs;
   endsequence
   property ptr_p;
      logic [3:0] v;
      wr_at(`OFS_SCAN_PTR) ##1 (1, v = hwdata[3:0]) |=> scanCount == v;
   endproperty
   property entry_p;
      logic [7:0] v;
      wr_at(`OFS_SCAN_ENTRY) ##1 (1, v = hwdata[7:0])
         |=> scanEnd == v[4] && chanPos[2:0] == v[2:0];
   endproperty
   property cmd_p;
      logic [7:0] v;
      wr_at(`OFS_TIMER_CMD) ##1 (1, v = hwdata[7:0])
         |-> ##[1:2] (timerCmdStb && timerCmd == v);
   endproperty
   property twr_p;
      logic [15:0] v;
      wr_at(`OFS_TIMER_DATA) ##1 (1, v = hwdata[15:0])
         |-> ##[1:2] (timerWrStb && timerWrData == v);
   endproperty
   ready_always_high_a: assert property (hreadyout)
      else $error("hreadyout dropped");
   response_okay_a: assert property (!hresp)
      else $error("error response seen");
   irq_on_rise_a: assert property ($rose(timer2Output) |-> ##[1:6] timerIrq)
      else $error("timer irq not raised");
   scan_pointer_a: assert property (ptr_p)
      else $error("scan counter not loaded");
   scan_entry_a: assert property (entry_p)
      else $error("scan entry not applied");
   timer_cmd_a: assert property (cmd_p)
      else $error("timer command not passed");
   timer_write_a: assert property (twr_p)
      else $error("timer data not passed");
   digital_read_a: assert property (rd_at(`OFS_DIGITAL_IN) ##0 quietCnt_r == 3'h7
      |=> hrdata == {24'h0, portBInputBits, portAInputBits})
      else $error("digital input read wrong");
   timer_status_a: assert property (rd_at(`OFS_TIMER_CMD) ##0 quietCnt_r == 3'h7
      |=> hrdata == {26'h0, timerOutLevels, bytePointerState})
      else $error("timer status read wrong");
endmodule
bind daq_board_register_file daq_board_register_file_chk chk_u (
   .clock, .srst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
   .hreadyout, .hresp, .timer2Output, .timerIrq, .scanCount, .chanPos,
   .scanEnd, .timerCmd, .timerCmdStb, .timerWrData, .timerWrStb,
   .timerOutLevels, .bytePointerState, .portAInputBits, .portBInputBits);

// *** tb/daq_board_register_file_bench.sv ***
// self-checking bench for the daq register file
`include "daq_regs_map.vh"
module daq_board_register_file_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock, srst, hsel, hwrite, convDone, timer2Output;
   logic        trigBusPulse, bytePointerState;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, rdv;
   logic [15:0] convResult, timerRdData;
   logic [4:0]  timerOutLevels;
   logic [3:0]  portAInputBits, portBInputBits;
   wire         hready, hreadyout, convReady, timerIrq, chanNegUsed, scanEnd;
   wire  [31:0] hrdata;
   wire  [11:0] aoutCh0, aoutCh1;
   wire  [3:0]  scanCount, chanPos, chanNeg;
   wire  [9:0]  ampGain;
   wire  [7:0]  timerCmd;
   wire  [15:0] timerWrData;
   int          n_mismatch, check_count;
   // low-gain codes first, then high-gain codes
   logic [9:0]  gains [8] = '{10'h001, 10'h00A, 10'h064, 10'h1F4,
                              10'h001, 10'h002, 10'h004, 10'h008};
   assign hready = hreadyout;  // single slave drives the bus ready
   daq_board_register_file #(.FIFO_DEPTH(4), .FIFO_AW(2)) dut_u (
      .clock, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hrdata, .hreadyout, .hresp(), .convDone, .convResult,
      .convReady, .timer2Output, .trigBusPulse, .aoutCh0, .aoutCh1,
      .timerIrq, .scanCount, .chanPos, .chanNeg, .chanNegUsed, .ampGain,
      .scanEnd, .timerCmd, .timerCmdStb(), .timerWrData, .timerWrStb(),
      .timerRdStb(), .timerRdData, .timerOutLevels, .bytePointerState,
      .portAInputBits, .portBInputBits);
   // 20 MHz clock
   always #25 clock = ~clock;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one single transfer; ends at the next falling edge so effects settle
   task automatic bus(input logic w, input logic [19:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      hsel   <= 1'h1;
      htrans <= `HTRANS_NONSEQ;
      hwrite <= w;
      haddr  <= {12'h000, a};
      do @(posedge clock); while (hready !== 1'h1);
      htrans <= 2'h0;
      hsel   <= 1'h0;
      hwdata <= d;
      do @(posedge clock); while (hready !== 1'h1);
      rdv = hrdata;
      @(negedge clock);
   endtask
   task automatic rdc(input logic [19:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      chk(rdv, e);
   endtask
   task automatic push(input logic [15:0] v);
      @(posedge clock);
      convDone   <= 1'h1;
      convResult <= v;
      @(posedge clock);
      convDone   <= 1'h0;
   endtask
   task automatic end_sim;
      if (n_mismatch == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      end_sim;
   end
   initial begin
      {clock, hsel, hwrite, convDone, timer2Output, trigBusPulse} = 6'h00;
      {htrans, haddr, hwdata, convResult} = 82'h0;
      {bytePointerState, timerOutLevels, timerRdData} = 22'h0;
      {portAInputBits, portBInputBits} = 8'h00;
      hsize = `HSIZE_WORD;
      srst = 1'h1;
      repeat (5) @(posedge clock);
      srst <= 1'h0;
      @(negedge clock);
      chk({aoutCh0, chanNeg, ampGain}, {12'h000, 4'h8, 10'h001});
      // analog output: immediate, timer pulse, trigger pulse
      bus(1'h1, `OFS_CONTROL, 32'h0);
      bus(1'h1, `OFS_AOUT0, 32'hFFFFFABC);
      chk(aoutCh0, 32'hABC);
      bus(1'h1, `OFS_CONTROL, 32'h1);
      bus(1'h1, `OFS_AOUT0, 32'h555);
      chk(aoutCh0, 32'hABC);
      timer2Output <= 1'h1;
      repeat (6) @(negedge clock);
      rdc(`OFS_STATUS, 32'h2);
      bus(1'h1, `OFS_IRQ_CLEAR, 32'h0);
      chk(timerIrq, 32'h0);
      timer2Output <= 1'h0;
      repeat (6) @(negedge clock);
      chk(aoutCh0, 32'h555);
      timer2Output <= 1'h1;
      repeat (6) @(negedge clock);
      bus(1'h1, `OFS_AOUT1, 32'h777);
      chk({timerIrq, aoutCh1}, 32'h000);
      bus(1'h1, `OFS_CONTROL, 32'h2);
      timer2Output <= 1'h0;
      repeat (6) @(negedge clock);
      chk(aoutCh1, 32'h0);
      trigBusPulse <= 1'h1;
      repeat (6) @(negedge clock);
      trigBusPulse <= 1'h0;
      repeat (6) @(negedge clock);
      chk(aoutCh1, 32'h777);
      // gain codes on both board variants
      for (int g = 0; g < 8; g++) begin
         bus(1'h1, `OFS_CONTROL, {27'h0, g[2], 4'h0});
         bus(1'h1, `OFS_SCAN_ENTRY, {24'h0, g[1:0], 6'h0});
         chk(ampGain, gains[g]);
      end
      // same select code, single-ended then differential
      for (int d = 0; d < 2; d++) begin
         bus(1'h1, `OFS_CONTROL, {28'h0, d[0], 3'h0});
         bus(1'h1, `OFS_SCAN_ENTRY, 32'h0000000B);
         chk({chanNegUsed, chanPos}, d ? 32'h13 : 32'h0B);
      end
      chk(chanNeg, 32'hB);
      // scan memory load, then revisit entries out of order
      bus(1'h1, `OFS_CONTROL, 32'h0);
      for (int i = 0; i < 4; i++) begin
         bus(1'h1, `OFS_SCAN_PTR, {28'hFFFFFFF, i[3:0]});
         bus(1'h1, `OFS_SCAN_ENTRY, {24'h0, i[1:0], 1'h0, i == 3,
                                    i[3:0] + 4'h5});
      end
      for (int i = 3; i >= 0; i--) begin
         bus(1'h1, `OFS_SCAN_PTR, {28'h0, i[3:0]});
         // the addressed entry reaches the front end one cycle later
         @(negedge clock);
         chk({scanCount, scanEnd, chanPos, ampGain},
             {i[3:0], i == 3, i[3:0] + 4'h5, gains[i]});
      end
      // fill the result fifo until it refuses, then drain it
      push(16'h0000);
      push(16'hFFFF);
      push(16'h8001);
      push(16'h7FFF);
      @(negedge clock);
      chk(convReady, 32'h0);
      rdc(`OFS_STATUS, 32'h5);
      rdc(`OFS_RESULT_FIFO, 32'h0000);
      rdc(`OFS_RESULT_FIFO, 32'hFFFF);
      bus(1'h1, `OFS_CONTROL, 32'h4);
      rdc(`OFS_RESULT_FIFO, 32'h0001);
      rdc(`OFS_RESULT_FIFO, 32'hFFFF);
      rdc(`OFS_STATUS, 32'h0);
      // timer window, timer status and digital inputs, two pin patterns
      for (int k = 0; k < 2; k++) begin
         timerOutLevels   <= k ? 5'h0A : 5'h15;
         bytePointerState <= k[0];
         portAInputBits   <= k ? 4'h6 : 4'h9;
         portBInputBits   <= k ? 4'h9 : 4'h6;
         timerRdData      <= k ? 16'h5A3C : 16'hC3A5;
         repeat (8) @(negedge clock);
         bus(1'h1, `OFS_TIMER_CMD, {16'h0, 8'hFF, 3'h0, k[0], 4'h7});
         chk(timerCmd, k ? 32'h17 : 32'h07);
         bus(1'h1, `OFS_TIMER_DATA, k ? 32'hF000 : 32'h0FF0);
         chk(timerWrData, k ? 32'hF000 : 32'h0FF0);
         rdc(`OFS_TIMER_DATA, k ? 32'h5A3C : 32'hC3A5);
         rdc(`OFS_TIMER_CMD, k ? 32'h15 : 32'h2A);
         rdc(`OFS_DIGITAL_IN, k ? 32'h96 : 32'h69);
      end
      rdc(20'h00050, 32'h0);
      end_sim;
   end
endmodule
